// ==== hw/quad_dac_pkg.sv ====
// Constants and types for the quad converter two-wire write path
package quad_dac_pkg;
  localparam int         NUM_CHANNELS   = 4;
  localparam int         WORD_WIDTH     = 14;
  localparam int         DATA_WIDTH     = 12;
  localparam logic [4:0] ADDR_FIXED     = 5'h13;
  localparam logic [4:0] HS_CODE_TOP    = 5'h01;
  localparam logic [1:0] LOAD_HOLD_ONLY = 2'h0;
  localparam logic [1:0] LOAD_ONE       = 2'h1;
  localparam logic [1:0] LOAD_ALL       = 2'h2;
  localparam logic [1:0] LOAD_BCAST     = 2'h3;
  localparam int         CTL_EXT_HI     = 7;
  localparam int         CTL_LOAD_HI    = 5;
  localparam int         CTL_LOAD_LO    = 4;
  localparam int         CTL_SEL_HI     = 2;
  localparam int         CTL_SEL_LO     = 1;
  localparam int         CTL_KIND       = 0;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ADDR   = 6'h02,
    ST_CTRL   = 6'h04,
    ST_HIGH   = 6'h08,
    ST_LOW    = 6'h10,
    ST_IGNORE = 6'h20
  } phase_type;

  typedef logic [WORD_WIDTH-1:0]                   word_type;
  typedef logic [NUM_CHANNELS-1:0][WORD_WIDTH-1:0] bank_type;

  typedef struct packed {
    logic [1:0] ext_addr;
    logic [1:0] pin_addr;
  } strap_type;

  typedef struct packed {
    phase_type  phase;
    logic [3:0] bit_cnt;
    logic       in_ack;
    logic [7:0] shreg;
    logic [7:0] ctrl;
    logic [7:0] high_byte;
    logic       sda_out;
    logic       sda_drive;
    logic       scl_meta;
    logic       scl_s;
    logic       scl_p;
    logic       sda_meta;
    logic       sda_s;
    logic       sda_p;
    strap_type  strap_meta;
    strap_type  strap_s;
    bank_type   hold;
    bank_type   outr;
  } state_type;
endpackage

// ==== hw/quad_dac_serial_write_path.sv ====
// Two-wire slave write path with per-channel holding and output registers
`timescale 1ns/1ps
module quad_dac_serial_write_path (
  input  wire logic                  core_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  input  wire quad_dac_pkg::strap_type strap_i,
  output quad_dac_pkg::bank_type     channel_holding_reg_o,
  output quad_dac_pkg::bank_type     channel_output_reg_o
);
  quad_dac_pkg::state_type st;
  quad_dac_pkg::state_type next_st;

  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_seen;
  logic                      stop_seen;
  logic                      ack_end;
  logic                      addr_match;
  logic                      hs_code;
  logic                      bcast;
  logic                      ext_match;
  logic                      ack_ok;
  logic [1:0]                sel;
  logic [1:0]                load;
  logic                      kind_pd;
  quad_dac_pkg::word_type    word_c;

  // Synchronised levels only; the first stage of each pair feeds nothing else
  assign scl_rise   = st.scl_s & ~st.scl_p;
  assign scl_fall   = ~st.scl_s & st.scl_p;
  assign start_seen = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
  assign stop_seen  = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
  assign ack_end    = scl_fall & st.in_ack;

  assign addr_match = (st.shreg[7:3] == quad_dac_pkg::ADDR_FIXED)
                    && (st.shreg[2:1] == st.strap_s.pin_addr)
                    && !st.shreg[0];
  assign hs_code    = (st.shreg[7:3] == quad_dac_pkg::HS_CODE_TOP);
  assign bcast      = (st.shreg[quad_dac_pkg::CTL_LOAD_HI:quad_dac_pkg::CTL_LOAD_LO]
                       == quad_dac_pkg::LOAD_BCAST);
  assign ext_match  = (st.shreg[quad_dac_pkg::CTL_EXT_HI -: 2] == st.strap_s.ext_addr);
  assign sel        = st.ctrl[quad_dac_pkg::CTL_SEL_HI:quad_dac_pkg::CTL_SEL_LO];
  assign load       = st.ctrl[quad_dac_pkg::CTL_LOAD_HI:quad_dac_pkg::CTL_LOAD_LO];
  assign kind_pd    = st.ctrl[quad_dac_pkg::CTL_KIND];

  always_comb begin
    case (st.phase)
      quad_dac_pkg::ST_ADDR: ack_ok = addr_match && !hs_code;
      quad_dac_pkg::ST_CTRL: ack_ok = bcast || ext_match;
      quad_dac_pkg::ST_HIGH: ack_ok = 1'b1;
      quad_dac_pkg::ST_LOW:  ack_ok = 1'b1;
      default:               ack_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_st            = st;
    word_c             = '0;
    next_st.scl_meta   = scl_i;
    next_st.scl_s      = st.scl_meta;
    next_st.scl_p      = st.scl_s;
    next_st.sda_meta   = sda_i;
    next_st.sda_s      = st.sda_meta;
    next_st.sda_p      = st.sda_s;
    next_st.strap_meta = strap_i;
    next_st.strap_s    = st.strap_meta;
    next_st.sda_out    = 1'b0;
    if (start_seen) begin
      // Repeated start always returns to addressing, also after the high-speed code
      next_st.phase     = quad_dac_pkg::ST_ADDR;
      next_st.bit_cnt   = '0;
      next_st.in_ack    = 1'b0;
      next_st.sda_drive = 1'b0;
    end else if (stop_seen) begin
      next_st.phase     = quad_dac_pkg::ST_IDLE;
      next_st.bit_cnt   = '0;
      next_st.in_ack    = 1'b0;
      next_st.sda_drive = 1'b0;
    end else if (scl_rise && !st.in_ack && st.phase != quad_dac_pkg::ST_IDLE
                 && st.bit_cnt < quad_dac_pkg::BITS_PER_BYTE) begin
      next_st.shreg   = {st.shreg[6:0], st.sda_s};
      next_st.bit_cnt = st.bit_cnt + 4'h1;
    end else if (ack_end) begin
      next_st.in_ack    = 1'b0;
      next_st.sda_drive = 1'b0;
      case (st.phase)
        quad_dac_pkg::ST_ADDR: next_st.phase = quad_dac_pkg::ST_CTRL;
        quad_dac_pkg::ST_CTRL: begin
          next_st.ctrl = st.shreg;
          if (bcast && !st.shreg[quad_dac_pkg::CTL_SEL_HI]) begin
            next_st.outr  = st.hold;
            next_st.phase = quad_dac_pkg::ST_IGNORE;
          end else begin
            next_st.phase = quad_dac_pkg::ST_HIGH;
          end
        end
        quad_dac_pkg::ST_HIGH: begin
          next_st.high_byte = st.shreg;
          next_st.phase     = quad_dac_pkg::ST_LOW;
        end
        quad_dac_pkg::ST_LOW: begin
          for (int c = 0; c < quad_dac_pkg::NUM_CHANNELS; c++) begin
            // Power-down words keep the channel's stored sample
            if (kind_pd) begin
              word_c = {st.high_byte[7:6], st.hold[c][quad_dac_pkg::DATA_WIDTH-1:0]};
            end else begin
              word_c = {2'h0, st.high_byte, st.shreg[7:4]};
            end
            if (load == quad_dac_pkg::LOAD_BCAST || sel == c[1:0]) begin
              next_st.hold[c] = word_c;
            end
          end
          // Outputs move here, on the falling clock that closes the ack
          case (load)
            quad_dac_pkg::LOAD_ONE:   next_st.outr[sel] = next_st.hold[sel];
            quad_dac_pkg::LOAD_ALL:   next_st.outr = next_st.hold;
            quad_dac_pkg::LOAD_BCAST: next_st.outr = next_st.hold;
            default:                  next_st.outr = st.outr;
          endcase
          // Only one power-down pair is taken; further bytes go unanswered
          next_st.phase = kind_pd ? quad_dac_pkg::ST_IGNORE : quad_dac_pkg::ST_HIGH;
        end
        default: next_st.phase = st.phase;
      endcase
    end else if (scl_fall && st.bit_cnt == quad_dac_pkg::BITS_PER_BYTE) begin
      next_st.bit_cnt   = '0;
      next_st.in_ack    = 1'b1;
      next_st.sda_drive = ack_ok;
      if (!ack_ok) begin
        next_st.phase = quad_dac_pkg::ST_IGNORE;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st          <= '0;
      st.phase    <= quad_dac_pkg::ST_IDLE;
      st.scl_meta <= 1'b1;
      st.scl_s    <= 1'b1;
      st.scl_p    <= 1'b1;
      st.sda_meta <= 1'b1;
      st.sda_s    <= 1'b1;
      st.sda_p    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sda_o                 = st.sda_out;
  assign sda_oe_o              = st.sda_drive;
  assign channel_holding_reg_o = st.hold;
  assign channel_output_reg_o  = st.outr;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  logic ack_start;
  assign ack_start = scl_fall && !st.in_ack && !start_seen && !stop_seen
                   && st.bit_cnt == quad_dac_pkg::BITS_PER_BYTE;

  property p_addr_needs_match;
    ack_start && st.phase == quad_dac_pkg::ST_ADDR && !addr_match |=> !sda_oe_o;
  endproperty
  a_addr_needs_match: assert property (p_addr_needs_match)
    else $error("ack on foreign address");

  property p_hs_no_ack;
    ack_start && st.phase == quad_dac_pkg::ST_ADDR && hs_code
      |=> !sda_oe_o && st.phase == quad_dac_pkg::ST_IGNORE;
  endproperty
  a_hs_no_ack: assert property (p_hs_no_ack)
    else $error("entry code acknowledged");

  property p_data_ack;
    ack_start && st.phase == quad_dac_pkg::ST_HIGH |=> sda_oe_o && !sda_o ##1 st.in_ack;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data byte not acknowledged");

  property p_out_only_at_ack_end;
    !$stable(channel_output_reg_o) |-> $past(ack_end);
  endproperty
  a_out_only_at_ack_end: assert property (p_out_only_at_ack_end)
    else $error("output moved off ack end");

  property p_low_nibble;
    ack_end && st.phase == quad_dac_pkg::ST_LOW && !kind_pd && load != quad_dac_pkg::LOAD_BCAST
      |=> channel_holding_reg_o[$past(sel)] == {2'h0, $past(st.high_byte), $past(st.shreg[7:4])};
  endproperty
  a_low_nibble: assert property (p_low_nibble)
    else $error("sample word wrong");

  property p_pd_two_bytes;
    ack_end && st.phase == quad_dac_pkg::ST_LOW && kind_pd |=> st.phase == quad_dac_pkg::ST_IGNORE;
  endproperty
  a_pd_two_bytes: assert property (p_pd_two_bytes)
    else $error("power-down took more bytes");

  property p_pairs_repeat;
    ack_end && st.phase == quad_dac_pkg::ST_LOW && !kind_pd |=> st.phase == quad_dac_pkg::ST_HIGH;
  endproperty
  a_pairs_repeat: assert property (p_pairs_repeat)
    else $error("pair did not repeat");

  property p_bcast_update;
    ack_end && st.phase == quad_dac_pkg::ST_CTRL && bcast && !st.shreg[quad_dac_pkg::CTL_SEL_HI]
      |=> channel_output_reg_o == $past(st.hold);
  endproperty
  a_bcast_update: assert property (p_bcast_update)
    else $error("broadcast update missed");

  property p_ctrl_kept;
    ack_end && st.phase == quad_dac_pkg::ST_CTRL |=> st.ctrl == $past(st.shreg) && !sda_oe_o;
  endproperty
  a_ctrl_kept: assert property (p_ctrl_kept)
    else $error("control byte lost");

  c_data_pair: cover property (ack_end && st.phase == quad_dac_pkg::ST_LOW && !kind_pd);
  c_pd_pair:   cover property (ack_end && st.phase == quad_dac_pkg::ST_LOW && kind_pd);
  c_hs_code:   cover property (ack_start && st.phase == quad_dac_pkg::ST_ADDR && hs_code);
  c_bcast:     cover property (ack_end && st.phase == quad_dac_pkg::ST_CTRL && bcast);
endmodule

// ==== sim/quad_dac_serial_write_path_bench.sv ====
// Self-checking bench for the two-wire write path
`timescale 1ns/1ps
module quad_dac_serial_write_path_bench;
  logic                   core_clk_i;
  logic                   srst_i;
  logic                   scl;
  logic                   sda_low;
  logic                   sda_o;
  logic                   sda_oe_o;
  logic                   sda_i;
  logic                   ack;
  quad_dac_pkg::strap_type strap;
  quad_dac_pkg::bank_type  hold;
  quad_dac_pkg::bank_type  outr;
  quad_dac_pkg::bank_type  eh;
  quad_dac_pkg::bank_type  eo;
  int                     err_total;
  int                     n_checks;

  // Open-drain data line with a pull-up
  assign sda_i = !(sda_low || (sda_oe_o && !sda_o));

  quad_dac_serial_write_path u_quad_dac_serial_write_path (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .strap_i(strap),
    .channel_holding_reg_o(hold), .channel_output_reg_o(outr));

  two_wire_master u_two_wire_master (
    .clk_i(core_clk_i), .sda_i(sda_i), .scl_o(scl), .sda_low_o(sda_low));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic exp_ack);
    u_two_wire_master.send_byte(b, ack);
    chk("acknowledge", {13'h0, exp_ack}, {13'h0, ack});
  endtask

  task automatic chk_bank();
    for (int c = 0; c < 4; c++) begin
      chk("holding", eh[c], hold[c]);
      chk("output", eo[c], outr[c]);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole run is near 7300 cycles; the limit leaves a wide margin
  initial begin
    repeat (50000) @(posedge core_clk_i);
    err_total++;
    results();
  end

  initial begin
    srst_i = 1'b1;
    strap = '{ext_addr: 2'h1, pin_addr: 2'h2};
    err_total = 0;
    n_checks = 0;
    eh = '0;
    eo = '0;
    repeat (5) @(posedge core_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'h54, 1'b1);
    wb(8'hab, 1'b1);
    wb(8'hcf, 1'b1);
    eh[2] = 14'h0abc;
    eo[2] = 14'h0abc;
    chk_bank();
    wb(8'h12, 1'b1);
    wb(8'h3a, 1'b1);
    u_two_wire_master.bus_stop();
    eh[2] = 14'h0123;
    eo[2] = 14'h0123;
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h9a, 1'b0);
    wb(8'h54, 1'b0);
    u_two_wire_master.bus_start();
    wb(8'h9d, 1'b0);
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'hd4, 1'b0);
    u_two_wire_master.bus_stop();
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'h42, 1'b1);
    wb(8'h5a, 1'b1);
    wb(8'h50, 1'b1);
    u_two_wire_master.bus_stop();
    eh[1] = 14'h05a5;
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'h55, 1'b1);
    wb(8'h80, 1'b1);
    wb(8'h0f, 1'b1);
    wb(8'h00, 1'b0);
    u_two_wire_master.bus_stop();
    eh[2] = 14'h2123;
    eo[2] = 14'h2123;
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h09, 1'b0);
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'h60, 1'b1);
    wb(8'h45, 1'b1);
    wb(8'h60, 1'b1);
    eh[0] = 14'h0456;
    eo = eh;
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'hf4, 1'b1);
    wb(8'h77, 1'b1);
    wb(8'h70, 1'b1);
    u_two_wire_master.bus_stop();
    eh = {4{14'h0777}};
    eo = eh;
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'h46, 1'b1);
    wb(8'h12, 1'b1);
    wb(8'h30, 1'b1);
    eh[3] = 14'h0123;
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'h30, 1'b1);
    wb(8'h55, 1'b0);
    u_two_wire_master.bus_stop();
    eo = eh;
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    wb(8'hb5, 1'b1);
    wb(8'h40, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h00, 1'b0);
    u_two_wire_master.bus_stop();
    eh = {14'h1123, 14'h1777, 14'h1777, 14'h1777};
    eo = eh;
    chk_bank();
    // A reset in mid-run must clear every holding and output register and leave the bus usable
    srst_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    eh = '0;
    eo = '0;
    chk_bank();
    u_two_wire_master.bus_start();
    wb(8'h9c, 1'b1);
    u_two_wire_master.bus_stop();
    results();
  end
endmodule

// ==== sim/two_wire_master.sv ====
// Behavioural two-wire bus master that stands on the far side of the write path
`timescale 1ns/1ps
module two_wire_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Doubles as repeated start: data is released before the clock goes high again
  task automatic bus_start();
    sda_low_o <= 1'b0;
    tick(6);
    scl_o <= 1'b1;
    tick(6);
    sda_low_o <= 1'b1;
    tick(6);
    scl_o <= 1'b0;
    tick(6);
  endtask

  task automatic bus_stop();
    sda_low_o <= 1'b1;
    tick(6);
    scl_o <= 1'b1;
    tick(6);
    sda_low_o <= 1'b0;
    tick(6);
  endtask

  // Data only moves while the clock is low, six cycles away from either clock edge
  task automatic send_byte(input logic [7:0] b, output logic acked);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o <= !b[i];
      tick(6);
      scl_o <= 1'b1;
      tick(6);
      scl_o <= 1'b0;
      tick(6);
    end
    sda_low_o <= 1'b0;
    tick(6);
    scl_o <= 1'b1;
    tick(3);
    acked = !sda_i;
    tick(3);
    scl_o <= 1'b0;
    tick(6);
  endtask
endmodule
